//--- sdf_pkg.sv
/*
  Shared constants for the step input and fault status block: status
  response layout, readback formats, fault limits and timing figures.
  Assumes a single 125 MHz system clock.
*/
`default_nettype none
package sdf_pkg;
  // Status response geometry.
  localparam int STATUS_W = 20;
  localparam int POS_W = 10;
  localparam int STALL_W = 10;
  localparam int COOL_W = 5;
  localparam int CUR_W = 5;
  localparam int CHOPPER_OFF_TIME_W = 4;
  // Field positions inside the status response.
  localparam int UPPER_LSB = 10;
  localparam int STANDSTILL_FLAG_BIT = 7;
  localparam int OLB_BIT = 6;
  localparam int OLA_BIT = 5;
  localparam int COIL_B_GROUND_SHORT_FLAG_BIT = 4;
  localparam int COIL_A_GROUND_SHORT_FLAG_BIT = 3;
  localparam int THERMAL_WARNING_FLAG_BIT = 2;
  localparam int OT_BIT = 1;
  localparam int SG_BIT = 0;
  // Readback format selection codes.
  typedef enum logic [1:0] {
    SDF_RD_POSITION = 2'h0,
    SDF_RD_STALL = 2'h1,
    SDF_RD_STALL_COOL = 2'h2,
    SDF_RD_RESERVED = 2'h3
  } sdf_readback_format_select_t;
  // Short counter limit that shuts the bridge down.
  localparam logic [1:0] SHORT_LIMIT = 2'h3;
  // Open-load clearing needs a current above max/16.
  localparam logic [CUR_W-1:0] CUR_MAX = 5'h1f;
  localparam int CUR_FRAC_SHIFT = 4;
  // Standstill timeout in system clock cycles.
  localparam int STANDSTILL_CYCLES = 1 << 20;
  localparam int STANDSTILL_W = 21;
  // Position bits that give coil polarities.
  localparam int POL_A_BIT = 9;
  localparam int POL_QUARTER_BIT = 8;
  localparam logic [CHOPPER_OFF_TIME_W-1:0] CHOPPER_OFF_TIME_OFF = 4'h0;
endpackage : sdf_pkg
`default_nettype wire

//--- sdf_step_input.sv
/*
  Step and direction synchroniser with edge selection.
  Assumes step_i and dir_i are already glitch filtered by the pad.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_step_input (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic dual_edge_stepping_i,
  output logic step_pulse_o,
  output logic dir_o
);
  import sdf_pkg::*;

  logic step_s1_q, step_s2_q, step_s3_q;
  logic dir_s1_q, dir_s2_q;
  wire logic step_rise;
  wire logic step_any;

  //////////////////////////////////////////////////////////////////////////
  // Two flops per input plus a third on step for edge history; the first stage is read only by the second.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_s1_q <= 1'b0;
      step_s2_q <= 1'b0;
      step_s3_q <= 1'b0;
      dir_s1_q <= 1'b0;
      dir_s2_q <= 1'b0;
    end else begin
      step_s1_q <= step_i; // RULE14
      step_s2_q <= step_s1_q;
      step_s3_q <= step_s2_q;
      dir_s1_q <= dir_i; // RULE14
      dir_s2_q <= dir_s1_q;
    end
  end

  // Edge detection works on the settled copies only.
  assign step_rise = step_s2_q & ~step_s3_q; // RULE13
  assign step_any = step_s2_q ^ step_s3_q; // RULE12
  assign step_pulse_o = dual_edge_stepping_i ? step_any : step_rise;
  assign dir_o = dir_s2_q;
endmodule // sdf_step_input
`default_nettype wire

//--- sdf_short_guard.sv
/*
  Short to ground tracking: per-coil flags, shared short counter and
  latched bridge shutdown. Assumes the short inputs are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_short_guard (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic driver_off_i,
  input wire logic short_a_i,
  input wire logic short_b_i,
  input wire logic polarity_change_i,
  output logic flag_a_o,
  output logic flag_b_o,
  output logic shutdown_o
);
  import sdf_pkg::*;

  logic [1:0] count_q, count_d;
  logic flag_a_q, flag_b_q, shutdown_q;
  wire logic [2:0] incr;
  wire logic [2:0] sum;

  // Both coils may short in one cycle; each counts once.
  assign incr = {2'h0, short_a_i} + {2'h0, short_b_i};
  assign sum = {1'b0, count_q} + incr - {2'h0, polarity_change_i & (count_q != 2'h0)};

  // Saturate at the limit so a burst cannot wrap the counter.
  always_comb begin
    count_d = (sum >= {1'b0, SHORT_LIMIT}) ? SHORT_LIMIT : sum[1:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Disabling the driver is the only way out of a latched shutdown.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= 2'h0;
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else if (driver_off_i) begin
      count_q <= 2'h0; // RULE19
      flag_a_q <= 1'b0; // RULE19
      flag_b_q <= 1'b0;
      shutdown_q <= 1'b0; // RULE8
    end else begin
      count_q <= count_d; // RULE5 RULE6
      flag_a_q <= flag_a_q | short_a_i; // RULE5
      flag_b_q <= flag_b_q | short_b_i; // RULE5
      shutdown_q <= shutdown_q | (count_d == SHORT_LIMIT); // RULE7
    end
  end

  assign flag_a_o = flag_a_q;
  assign flag_b_o = flag_b_q;
  assign shutdown_o = shutdown_q;
endmodule // sdf_short_guard
`default_nettype wire

//--- sdf_status_top.sv
/*
  Step/direction input and diagnostic status block of a stepper driver.
  Holds the microstep position, standstill timer, open-load, short to
  ground, thermal and stall flags, and builds the 20-bit status response
  returned for each serial write command.
  Assumes the serial interface gives a one-cycle write strobe, and that
  the chopper, thermal sensor and stall detector deliver their events
  synchronous to clock_i.
*/
// Summary of operation
// RULE1 - Open load set if no chop event
// RULE2 - Open load clears only above max/16 current
// RULE3 - Open load flags take no protective action
// RULE4 - Controller checks open load during slow motion
// RULE5 - Short sets flag, counts, suspends chopper
// RULE6 - Each polarity change decrements short counter
// RULE7 - Counter at three shuts bridge off
// RULE8 - Only disable and re-enable clears shutdown
// RULE9 - Thermal warning follows active warning threshold
// RULE10 - Thermal shutdown flag set once it occurred
// RULE11 - Stall sets flag and drives test pin
// RULE12 - Dual edge: both step edges active
// RULE13 - Single edge: only rising step edges
// RULE14 - Step and dir synchronised before use
// RULE15 - Controller limits step rate to clock fraction
// RULE16 - Standstill after 2^20 idle clock cycles
// RULE17 - Step counts up dir 0, down dir 1
// RULE18 - Every write returns formatted 20-bit status
// RULE19 - Disabling clears short counter and flags
`timescale 1ns/1ps
`default_nettype none
module sdf_status_top #(
  parameter int STANDSTILL_CYCLES_P = sdf_pkg::STANDSTILL_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Step/direction link from the motion controller.
  input wire logic step_i,
  input wire logic dir_i,
  // Drive control and configuration fields.
  input wire logic dual_edge_stepping_i,
  input wire logic [sdf_pkg::POS_W-1:0] step_increment_i,
  input wire logic driver_enable_low_input_i,
  input wire logic [sdf_pkg::CHOPPER_OFF_TIME_W-1:0] chopper_off_time_i,
  input wire logic [1:0] readback_format_select_i,
  input wire logic [sdf_pkg::CUR_W-1:0] current_scale_i,
  // Events from the chopper and sensors.
  input wire logic chop_event_a_i,
  input wire logic chop_event_b_i,
  input wire logic short_a_i,
  input wire logic short_b_i,
  input wire logic thermal_warning_i,
  input wire logic thermal_shutdown_i,
  input wire logic stall_reached_i,
  input wire logic [sdf_pkg::STALL_W-1:0] stall_value_i,
  input wire logic [sdf_pkg::COOL_W-1:0] cool_scale_i,
  // Serial write command strobe.
  input wire logic write_cmd_i,
  output logic [sdf_pkg::STATUS_W-1:0] driver_status_response_o,
  output logic status_valid_o,
  output logic [sdf_pkg::POS_W-1:0] microstep_position_o,
  output logic standstill_flag_o,
  output logic stall_test_pin_o,
  output logic bridge_enable_o,
  output logic chopper_suspend_o
);
  import sdf_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; the rest uses rst_n.
  // The pin reset asserts at once but lifts only on a clock edge, so no
  // flop sees its reset release in the middle of a setup window.
  logic rst_s1_q, rst_n;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Step input conditioning.
  wire logic step_pulse;
  wire logic dir_sync;

  sdf_step_input u_step (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .step_i(step_i),
    .dir_i(dir_i),
    .dual_edge_stepping_i(dual_edge_stepping_i),
    .step_pulse_o(step_pulse),
    .dir_o(dir_sync)
  );

  // The controller must respect the maximum step rate; an edge closer
  // than the synchroniser can resolve is simply missed.
  // An accepted edge reaches the counter on the third clock edge after the pin moves.
  // RULE15

  //////////////////////////////////////////////////////////////////////////
  // Microstep position counter.
  logic [POS_W-1:0] pos_q;
  wire logic [POS_W-1:0] pos_d;

  // Direction comes from the synchronised copy, so it lines up with the edge.
  // The counter wraps freely, as the electrical angle does.
  assign pos_d = dir_sync ? (pos_q - step_increment_i) : (pos_q + step_increment_i); // RULE17

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= '0;
    end else if (step_pulse) begin
      pos_q <= pos_d; // RULE17
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Standstill timer; saturates so the flag holds until the next edge.
  localparam logic [STANDSTILL_W-1:0] STANDSTILL_FLAG_LAST = STANDSTILL_W'(STANDSTILL_CYCLES_P - 1);
  logic [STANDSTILL_W-1:0] idle_q;
  logic standstill_flag_q;
  wire logic idle_done;

  assign idle_done = (idle_q == STANDSTILL_FLAG_LAST);

  // The count stops at the last value rather than wrapping, which keeps a
  // long pause from ever dropping the standstill indication by itself.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= '0;
      standstill_flag_q <= 1'b0;
    end else if (step_pulse) begin
      idle_q <= '0;
      standstill_flag_q <= 1'b0;
    end else begin
      idle_q <= idle_done ? idle_q : idle_q + 1'b1;
      standstill_flag_q <= standstill_flag_q | idle_done; // RULE16
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Coil polarities come from the position: coil B leads by 256.
  wire logic pol_a;
  wire logic pol_b;
  logic pol_a_q, pol_b_q;
  wire logic flip_a;
  wire logic flip_b;

  assign pol_a = pos_q[POL_A_BIT];
  assign pol_b = pos_q[POL_A_BIT] ^ pos_q[POL_QUARTER_BIT];
  assign flip_a = pol_a ^ pol_a_q;
  assign flip_b = pol_b ^ pol_b_q;

  // Last polarities; a difference from the live value marks a flip cycle.
  // After reset both sides read zero, so no false flip follows release.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pol_a_q <= 1'b0;
      pol_b_q <= 1'b0;
    end else begin
      pol_a_q <= pol_a;
      pol_b_q <= pol_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Open-load detection per coil. Flags are status only; nothing in the
  // drive path reads them. Checking is the controller's job at slow speed.
  // RULE3 RULE4
  wire logic current_high;
  logic seen_a_q, seen_b_q, ola_q, olb_q;

  // Current times sixteen is compared with full scale, so no divider is
  // needed; settings of one or zero never clear a flag.
  assign current_high = ({current_scale_i, CUR_FRAC_SHIFT'(0)} > {CUR_FRAC_SHIFT'(0), CUR_MAX}); // RULE2

  // An event in the flip cycle belongs to the interval that just ended.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seen_a_q <= 1'b0;
      ola_q <= 1'b0;
    end else if (flip_a) begin
      seen_a_q <= 1'b0;
      if (!(seen_a_q | chop_event_a_i)) begin
        ola_q <= 1'b1; // RULE1
      end else if (current_high) begin
        ola_q <= 1'b0; // RULE2
      end
    end else begin
      seen_a_q <= seen_a_q | chop_event_a_i;
    end
  end

  // Coil B follows the same scheme with its own event history.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seen_b_q <= 1'b0;
      olb_q <= 1'b0;
    end else if (flip_b) begin
      seen_b_q <= 1'b0;
      if (!(seen_b_q | chop_event_b_i)) begin
        olb_q <= 1'b1; // RULE1
      end else if (current_high) begin
        olb_q <= 1'b0; // RULE2
      end
    end else begin
      seen_b_q <= seen_b_q | chop_event_b_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Short to ground handling; off means enable pin high or off-time zero.
  wire logic driver_off;
  wire logic coil_a_ground_short_flag;
  wire logic coil_b_ground_short_flag;
  wire logic short_shutdown;

  // Either off condition alone is enough; a short pulse in the same cycle
  // is neither flagged nor counted, but it still sets the chopper suspend.
  assign driver_off = driver_enable_low_input_i | (chopper_off_time_i == CHOPPER_OFF_TIME_OFF); // RULE8

  // Any polarity flip of either coil counts as one phase change.
  sdf_short_guard u_short (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .driver_off_i(driver_off),
    .short_a_i(short_a_i),
    .short_b_i(short_b_i),
    .polarity_change_i(flip_a | flip_b),
    .flag_a_o(coil_a_ground_short_flag),
    .flag_b_o(coil_b_ground_short_flag),
    .shutdown_o(short_shutdown)
  );

  //////////////////////////////////////////////////////////////////////////
  // Thermal and stall flags, bridge control and chopper suspend.
  // Thermal shutdown also holds the bridge off until the driver is cycled.
  logic thermal_warning_flag_q, ot_q, sg_q, bridge_q, suspend_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      thermal_warning_flag_q <= 1'b0;
      ot_q <= 1'b0;
      sg_q <= 1'b0;
      bridge_q <= 1'b0;
      suspend_q <= 1'b0;
    end else begin
      thermal_warning_flag_q <= thermal_warning_i; // RULE9
      // A new shutdown event wins over the clear by disabling.
      ot_q <= thermal_shutdown_i | (ot_q & ~driver_off); // RULE10
      sg_q <= stall_reached_i; // RULE11
      bridge_q <= ~driver_off & ~short_shutdown & ~ot_q; // RULE7
      suspend_q <= short_a_i | short_b_i; // RULE5
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status response assembly, captured on each write command.
  wire logic [POS_W-1:0] upper_field;
  wire logic [STATUS_W-1:0] status_word;
  logic [STATUS_W-1:0] resp_q;
  logic valid_q;

  // The reserved select code returns zeros rather than repeating a field.
  assign upper_field =
    (readback_format_select_i == SDF_RD_POSITION) ? pos_q :
    (readback_format_select_i == SDF_RD_STALL) ? stall_value_i :
    (readback_format_select_i == SDF_RD_STALL_COOL) ?
      {stall_value_i[STALL_W-1:COOL_W], cool_scale_i} : '0;

  assign status_word = {upper_field, 2'h0, standstill_flag_q, olb_q, ola_q,
                        coil_b_ground_short_flag, coil_a_ground_short_flag, thermal_warning_flag_q, ot_q, sg_q};

  // The response is frozen at the strobe edge and holds until the next one.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= write_cmd_i;
      if (write_cmd_i) begin
        resp_q <= status_word; // RULE18
      end
    end
  end

  // Every output is a flop, so the pins never show decode glitches.
  assign driver_status_response_o = resp_q;
  assign status_valid_o = valid_q;
  assign microstep_position_o = pos_q;
  assign standstill_flag_o = standstill_flag_q;
  assign stall_test_pin_o = sg_q; // RULE11
  assign bridge_enable_o = bridge_q;
  assign chopper_suspend_o = suspend_q;
endmodule // sdf_status_top
`default_nettype wire

//--- sdf_status_top_chk.sv
/*
  Port-level assertions for the step input and fault status block.
  Assumes it is bound into every sdf_status_top instance.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_status_top_chk #(
  parameter int STANDSTILL_CYCLES_P = 64
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic driver_enable_low_input_i,
  input wire logic [sdf_pkg::CHOPPER_OFF_TIME_W-1:0] chopper_off_time_i,
  input wire logic [1:0] readback_format_select_i,
  input wire logic short_a_i,
  input wire logic short_b_i,
  input wire logic thermal_warning_i,
  input wire logic stall_reached_i,
  input wire logic [sdf_pkg::STALL_W-1:0] stall_value_i,
  input wire logic write_cmd_i,
  input wire logic [sdf_pkg::STATUS_W-1:0] driver_status_response_o,
  input wire logic status_valid_o,
  input wire logic [sdf_pkg::POS_W-1:0] microstep_position_o,
  input wire logic standstill_flag_o,
  input wire logic stall_test_pin_o,
  input wire logic bridge_enable_o,
  input wire logic chopper_suspend_o
);
  import sdf_pkg::*;
  // One clock domain; the pin reset silences every check.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic off_w = driver_enable_low_input_i || (chopper_off_time_i == CHOPPER_OFF_TIME_OFF);
  ////////////////////////////////////////////////////////////////////////////////
  valid_after_write_a: assert property (write_cmd_i |=> status_valid_o)
    else $error("no valid after write");
  valid_cause_a: assert property (status_valid_o |-> $past(write_cmd_i))
    else $error("valid without write");
  reserved_zero_a: assert property (
    status_valid_o |-> driver_status_response_o[9:8] == 2'h0)
    else $error("reserved bits set");
  upper_blank_a: assert property (
    write_cmd_i && readback_format_select_i == 2'h3 |=> driver_status_response_o[19:10] == 10'h0)
    else $error("reserved format not zero");
  stall_field_a: assert property (
    write_cmd_i && readback_format_select_i == 2'h1 && $stable(stall_value_i)
    |=> driver_status_response_o[19:10] == $past(stall_value_i))
    else $error("stall field wrong");
  pos_field_a: assert property (
    write_cmd_i && readback_format_select_i == 2'h0 && $stable(microstep_position_o)
    |=> driver_status_response_o[19:10] == $past(microstep_position_o))
    else $error("position field wrong");
  warn_flag_a: assert property (
    write_cmd_i && $stable(thermal_warning_i)
    |=> driver_status_response_o[THERMAL_WARNING_FLAG_BIT] == $past(thermal_warning_i))
    else $error("warning flag wrong");
  stall_flag_a: assert property (
    stall_reached_i ##1 (stall_reached_i && write_cmd_i)
    |=> driver_status_response_o[SG_BIT] && stall_test_pin_o)
    else $error("stall flag or pin low");
  bridge_off_a: assert property (off_w |=> !bridge_enable_o)
    else $error("bridge on while driver off");
  short_suspend_a: assert property ((short_a_i || short_b_i) |=> chopper_suspend_o)
    else $error("no suspend after short");
  suspend_cause_a: assert property (chopper_suspend_o |-> $past(short_a_i || short_b_i))
    else $error("suspend without short");
  moving_clear_a: assert property ($changed(microstep_position_o) |-> !standstill_flag_o)
    else $error("standstill while moving");
  // Main scenarios reached.
  cover property (write_cmd_i && readback_format_select_i == 2'h2);
  cover property ($fell(bridge_enable_o));
  cover property ($rose(standstill_flag_o));
endmodule // sdf_status_top_chk
bind sdf_status_top sdf_status_top_chk #(.STANDSTILL_CYCLES_P(STANDSTILL_CYCLES_P)) u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .driver_enable_low_input_i(driver_enable_low_input_i),
  .chopper_off_time_i(chopper_off_time_i), .readback_format_select_i(readback_format_select_i),
  .short_a_i(short_a_i), .short_b_i(short_b_i), .thermal_warning_i(thermal_warning_i),
  .stall_reached_i(stall_reached_i), .stall_value_i(stall_value_i),
  .write_cmd_i(write_cmd_i), .driver_status_response_o(driver_status_response_o),
  .status_valid_o(status_valid_o), .microstep_position_o(microstep_position_o),
  .standstill_flag_o(standstill_flag_o), .stall_test_pin_o(stall_test_pin_o),
  .bridge_enable_o(bridge_enable_o), .chopper_suspend_o(chopper_suspend_o));
`default_nettype wire

//--- sdf_step_ctrl_model.sv
/*
  Motion controller model: each request makes one step level change.
  Assumes the bench waits for busy_o to drop before the next request.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_step_ctrl_model #(
  parameter int HOLD_P = 3
) (
  input wire logic clock_i,
  input wire logic req_i,
  input wire logic dir_req_i,
  output logic step_o,
  output logic dir_o,
  output logic busy_o
);
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    busy_o = 1'b0;
  end
  // Direction leads the step edge and every level lasts several clocks.
  always @(posedge clock_i) begin
    if (req_i) begin
      @(negedge clock_i);
      busy_o = 1'b1;
      dir_o = dir_req_i;
      repeat (HOLD_P) @(negedge clock_i);
      step_o = ~step_o;
      repeat (2 * HOLD_P) @(negedge clock_i);
      busy_o = 1'b0;
    end
  end
endmodule // sdf_step_ctrl_model
`default_nettype wire

//--- sdf_status_top_tb_top.sv
/*
  Self-checking bench for sdf_status_top and a step generator model.
  Assumes the checker file is compiled too and binds itself.
*/
`timescale 1ns/1ps
`default_nettype none
module sdf_status_top_tb_top;
  import sdf_pkg::*;
  localparam int SS_P = 64;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic dual_q = 1'b0;
  logic dir_q = 1'b0;
  logic req_q = 1'b0;
  logic en_b_q = 1'b0;
  logic wr_q = 1'b0;
  logic twarn_q = 1'b0;
  logic stall_q = 1'b0;
  logic [4:0] ev_q = 5'h00;
  logic [3:0] chopper_off_time_q = 4'h4;
  logic [1:0] readback_format_select_q = 2'h0;
  logic [4:0] cur_q = 5'h1f;
  logic [9:0] inc_q = 10'h001;
  logic [9:0] sval_q = 10'h2a5;
  logic [4:0] cool_q = 5'h13;
  logic [9:0] pos_q = 10'h000;
  logic [19:0] got_q;
  wire logic [19:0] resp_w;
  wire logic [9:0] pos_w;
  wire logic step_w, dir_w, busy_w, valid_w, standstill_flag_w, pin_w, bridge_w, susp_w;
  int fails = 0;
  int tests_run = 0;
  always #4 clock_i = ~clock_i;
  // Event lines: 0/1 shorts, 2/3 chopper events, 4 thermal shutdown.
  sdf_step_ctrl_model u_sdf_step_ctrl_model (.clock_i(clock_i), .req_i(req_q),
    .dir_req_i(dir_q), .step_o(step_w), .dir_o(dir_w), .busy_o(busy_w));
  sdf_status_top #(.STANDSTILL_CYCLES_P(SS_P)) u_sdf_status_top (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .step_i(step_w), .dir_i(dir_w),
    .dual_edge_stepping_i(dual_q), .step_increment_i(inc_q),
    .driver_enable_low_input_i(en_b_q), .chopper_off_time_i(chopper_off_time_q),
    .readback_format_select_i(readback_format_select_q), .current_scale_i(cur_q),
    .chop_event_a_i(ev_q[2]), .chop_event_b_i(ev_q[3]), .short_a_i(ev_q[0]),
    .short_b_i(ev_q[1]), .thermal_warning_i(twarn_q), .thermal_shutdown_i(ev_q[4]),
    .stall_reached_i(stall_q), .stall_value_i(sval_q), .cool_scale_i(cool_q),
    .write_cmd_i(wr_q), .driver_status_response_o(resp_w), .status_valid_o(valid_w),
    .microstep_position_o(pos_w), .standstill_flag_o(standstill_flag_w), .stall_test_pin_o(pin_w),
    .bridge_enable_o(bridge_w), .chopper_suspend_o(susp_w));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A write strobe; the response is taken while valid stands.
  task automatic rd;
    @(negedge clock_i);
    wr_q = 1'b1;
    @(negedge clock_i);
    wr_q = 1'b0;
    got_q = resp_w;
    cmp("valid", 20'h1, {19'h0, valid_w});
  endtask
  task automatic pulse(input int k);
    @(negedge clock_i);
    ev_q[k] = 1'b1;
    @(negedge clock_i);
    ev_q = 5'h00;
  endtask
  // One step level change; the expected position follows the edge mode.
  task automatic step(input logic d);
    int n;
    @(negedge clock_i);
    dir_q = d;
    req_q = 1'b1;
    @(negedge clock_i);
    req_q = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (!busy_w) break;
    end
    if (busy_w) begin
      fails++;
      stop_test();
    end
    if (dual_q || step_w) pos_q = d ? pos_q - inc_q : pos_q + inc_q;
    @(negedge clock_i);
  endtask
  task automatic reenable(input logic by_chopper_off_time);
    @(negedge clock_i);
    if (by_chopper_off_time) chopper_off_time_q = 4'h0;
    else en_b_q = 1'b1;
    repeat (2) @(negedge clock_i);
    chopper_off_time_q = 4'h4;
    en_b_q = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: stepping, status formats, thermal, shorts, open load.
  initial begin
    int i;
    logic [9:0] up;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clock_i);
    cmp("bridge", 20'h1, {19'h0, bridge_w});
    for (i = 0; i < 4; i++)
      step(1'b0);
    cmp("position up", {10'h0, pos_q}, {10'h0, pos_w});
    dual_q = 1'b1;
    for (i = 0; i < 3; i++)
      step(1'b1);
    cmp("position down", {10'h0, pos_q}, {10'h0, pos_w});
    cmp("moving", 20'h0, {19'h0, standstill_flag_w});
    repeat (SS_P + 8) @(negedge clock_i);
    for (i = 0; i < 4; i++) begin
      readback_format_select_q = i[1:0];
      up = (i == 0) ? pos_q : (i == 1) ? sval_q : (i == 2) ? {sval_q[9:5], cool_q} : 10'h0;
      rd();
      cmp("upper field", {10'h0, up}, {10'h0, got_q[19:10]});
      // The wrap below zero flipped coil A with no chopper event seen.
      cmp("low field", 20'ha0, {10'h0, got_q[9:0]});
    end
    readback_format_select_q = 2'h0;
    twarn_q = 1'b1;
    stall_q = 1'b1;
    pulse(4);
    rd();
    cmp("thermal and stall", 20'h7, {17'h0, got_q[2:0]});
    cmp("test pin", 20'h1, {19'h0, pin_w});
    twarn_q = 1'b0;
    stall_q = 1'b0;
    rd();
    cmp("sticky shutdown", 20'h2, {17'h0, got_q[2:0]});
    // Both ways of disabling: the enable pin clears the thermal shutdown, zero off-time a latched short one.
    for (i = 0; i < 2; i++) begin
      reenable(i[0]);
      rd();
      cmp("cleared", 20'h0, {17'h0, got_q[4:3], got_q[1]});
      cmp("bridge on", 20'h1, {19'h0, bridge_w});
      repeat (3) pulse(0);
      repeat (20) @(negedge clock_i);
      cmp("bridge latched off", 20'h0, {19'h0, bridge_w});
      rd();
      cmp("short flags", 20'h1, {18'h0, got_q[4:3]});
    end
    reenable(1'b0);
    inc_q = 10'h100;
    pulse(0);
    pulse(1);
    step(1'b0);
    pulse(0);
    repeat (4) @(negedge clock_i);
    cmp("bridge after decrement", 20'h1, {19'h0, bridge_w});
    rd();
    cmp("both shorts", 20'h3, {18'h0, got_q[4:3]});
    pulse(0);
    cmp("suspend", 20'h1, {19'h0, susp_w});
    repeat (4) @(negedge clock_i);
    cmp("bridge at three", 20'h0, {19'h0, bridge_w});
    // Slow motion: each step flips one coil; current 1 keeps, 2 clears.
    reenable(1'b0);
    for (i = 0; i < 3; i++) begin
      cur_q = (i == 2) ? 5'h02 : 5'h01;
      if (i > 0) begin
        pulse(2);
        pulse(3);
      end
      repeat ((i == 0) ? 4 : 2) step(1'b0);
      rd();
      cmp("open load", (i == 2) ? 20'h0 : 20'h3, {18'h0, got_q[6:5]});
      cmp("bridge with open load", 20'h1, {19'h0, bridge_w});
    end
    stop_test();
  end
endmodule // sdf_status_top_tb_top
`default_nettype wire
